// ===== core/rfx_ctl.sv
// Overview of operation
// - reset outranks all exceptions and aborts current work without resume.
// - reset sets supervisor bit and clears trace enable in status word.
// - reset clears master bit and sets interrupt mask to level seven.
// - reset loads the vector base pointer with zero.
// - reset invalidates local cache and ram configuration, disabling them.
// - after reset release, unless held halted, issue two longword reads.
// - program counter comes from address zero; run after first fetch.
// - access or address error before first instruction enters halt.
// - valid opcode lacking optional unit raises exception vector 0x61.
// - fault during exception processing of a fault halts at once.
// - halted state holds until reset; system must assert reset.
`include "rfx_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module rfx_ctl
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic reset_request_in_n,
  input wire logic hold_halt,
  output rfx_pkg::rfx_bus_req_t bus_req,
  input wire rfx_pkg::rfx_bus_rsp_t bus_rsp,
  input wire logic fetch_done,
  input wire logic opcode_valid,
  input wire logic unit_absent,
  input wire logic fault,
  input wire logic exc_done,
  output logic exc_take,
  output logic [7:0] exc_vector,
  output logic core_run,
  output logic halted,
  output logic [15:0] processor_status_word,
  output logic [31:0] vector_base_pointer,
  output logic [31:0] program_counter,
  output logic [31:0] stack_pointer,
  output logic local_mem_valid,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [31:0] reg_rdata,
  output logic irq
);
  // ********************************************************
  // helpers
  // ********************************************************
  // status word as it stands after a reset exception
  function automatic logic [15:0] rfx_reset_sr(input logic [15:0] sr);
    logic [15:0] r;
    r = sr;
    r[`RFX_SR_S_BIT] = 1'b1;
    r[`RFX_SR_T_BIT] = 1'b0;
    r[`RFX_SR_M_BIT] = 1'b0;
    r[`RFX_SR_IPL_MSB:`RFX_SR_IPL_LSB] = `RFX_IPL_MAX;
    return r;
  endfunction

  function automatic logic bus_fault(input rfx_pkg::rfx_bus_rsp_t rsp);
    return rsp.ack & (rsp.access_err | rsp.addr_err);
  endfunction

  // ********************************************************
  // reset request input
  // ********************************************************
  logic rst_sync;
  logic rst_active;

  rfx_sync u_sync
  (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .din(reset_request_in_n),
    .dout(rst_sync)
  );

  assign rst_active = ~rst_sync;

  // ********************************************************
  // sequencer
  // ********************************************************
  rfx_pkg::rfx_state_t st_q;
  rfx_pkg::rfx_state_t st_d;
  logic [15:0] sr_q;
  logic [15:0] sr_d;
  logic [31:0] vbr_q;
  logic [31:0] vbr_d;
  logic [31:0] pc_q;
  logic [31:0] pc_d;
  logic [31:0] sp_q;
  logic [31:0] sp_d;
  logic lmv_q;
  logic lmv_d;
  logic in_exc_q;
  logic in_exc_d;
  logic take_q;
  logic take_d;
  logic [7:0] vec_q;
  logic [7:0] vec_d;
  logic lmv_wr;
  logic [3:0] evt;
  logic unsupp;

  assign unsupp = opcode_valid & unit_absent;
  assign lmv_wr = reg_we && (reg_addr == `RFX_REG_CTRL);

  // reset dominates every branch; halt is left only through reset
  always_comb
  begin
    st_d = st_q;
    sr_d = sr_q;
    vbr_d = vbr_q;
    pc_d = pc_q;
    sp_d = sp_q;
    lmv_d = lmv_wr ? reg_wdata[0] : lmv_q;
    in_exc_d = in_exc_q;
    take_d = 1'b0;
    vec_d = vec_q;
    evt = 4'h0;
    if (rst_active)
    begin
      st_d = rfx_pkg::RFX_ST_RESET;
      sr_d = rfx_reset_sr(sr_q);
      vbr_d = `RFX_VBR_RESET;
      lmv_d = 1'b0;
      in_exc_d = 1'b0;
      evt[0] = (st_q != rfx_pkg::RFX_ST_RESET);
    end
    else
    begin
      unique case (st_q)
        rfx_pkg::RFX_ST_RESET:
        begin
          if (!hold_halt)
            st_d = rfx_pkg::RFX_ST_RD0;
        end
        rfx_pkg::RFX_ST_RD0:
        begin
          if (bus_fault(bus_rsp))
            st_d = rfx_pkg::RFX_ST_HALT;
          else if (bus_rsp.ack)
          begin
            pc_d = bus_rsp.data;
            st_d = rfx_pkg::RFX_ST_RD1;
          end
        end
        rfx_pkg::RFX_ST_RD1:
        begin
          if (bus_fault(bus_rsp))
            st_d = rfx_pkg::RFX_ST_HALT;
          else if (bus_rsp.ack)
          begin
            sp_d = bus_rsp.data;
            st_d = rfx_pkg::RFX_ST_FETCH;
          end
        end
        rfx_pkg::RFX_ST_FETCH:
        begin
          if (fault || bus_fault(bus_rsp))
            st_d = rfx_pkg::RFX_ST_HALT;
          else if (fetch_done)
            st_d = rfx_pkg::RFX_ST_RUN;
        end
        rfx_pkg::RFX_ST_RUN:
        begin
          if (in_exc_q && fault)
          begin
            st_d = rfx_pkg::RFX_ST_HALT;
            in_exc_d = 1'b0;
          end
          else if (fault)
          begin
            in_exc_d = 1'b1;
            evt[2] = 1'b1;
          end
          else if (unsupp && !in_exc_q)
          begin
            take_d = 1'b1;
            vec_d = `RFX_VEC_UNSUPP;
            evt[1] = 1'b1;
          end
          else if (exc_done)
            in_exc_d = 1'b0;
        end
        rfx_pkg::RFX_ST_HALT:
        begin
          st_d = rfx_pkg::RFX_ST_HALT;
        end
      endcase
      if (st_d == rfx_pkg::RFX_ST_HALT && st_q != rfx_pkg::RFX_ST_HALT)
        evt[3] = 1'b1;
    end
  end

  // register stage only; values frozen while ce is low
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      st_q <= rfx_pkg::RFX_ST_RESET;
      sr_q <= `RFX_SR_RESET;
      vbr_q <= `RFX_VBR_RESET;
      pc_q <= 32'h00000000;
      sp_q <= 32'h00000000;
      lmv_q <= 1'b0;
      in_exc_q <= 1'b0;
      take_q <= 1'b0;
      vec_q <= 8'h00;
    end
    else if (ce)
    begin
      st_q <= st_d;
      sr_q <= sr_d;
      vbr_q <= vbr_d;
      pc_q <= pc_d;
      sp_q <= sp_d;
      lmv_q <= lmv_d;
      in_exc_q <= in_exc_d;
      take_q <= take_d;
      vec_q <= vec_d;
    end
  end

  // ********************************************************
  // bus requests and status outputs
  // ********************************************************
  // read request held until ack; first word is the counter
  always_comb
  begin
    bus_req.req = (st_q == rfx_pkg::RFX_ST_RD0) ||
                  (st_q == rfx_pkg::RFX_ST_RD1);
    bus_req.addr = (st_q == rfx_pkg::RFX_ST_RD1) ?
                   `RFX_RESET_SP_ADDR : `RFX_RESET_PC_ADDR;
  end

  assign halted = (st_q == rfx_pkg::RFX_ST_HALT);
  assign core_run = (st_q == rfx_pkg::RFX_ST_RUN);
  assign exc_take = take_q;
  assign exc_vector = vec_q;
  assign processor_status_word = sr_q;
  assign vector_base_pointer = vbr_q;
  assign program_counter = pc_q;
  assign stack_pointer = sp_q;
  assign local_mem_valid = lmv_q;

  // ********************************************************
  // register port and interrupts
  // ********************************************************
  logic [3:0] int_status;
  logic [3:0] int_mask;
  logic [31:0] rd_q;
  logic [31:0] rd_d;

  rfx_irq u_irq
  (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .evt(evt),
    .clr_we(reg_we && (reg_addr == `RFX_REG_STATUS)),
    .clr_bits(reg_wdata[3:0]),
    .mask_we(reg_we && (reg_addr == `RFX_REG_MASK)),
    .mask_wdata(reg_wdata[3:0]),
    .status(int_status),
    .mask(int_mask),
    .irq(irq)
  );

  // read data valid only in the cycle after the strobe
  always_comb
  begin
    rd_d = 32'h00000000;
    if (reg_re)
    begin
      case (reg_addr)
        `RFX_REG_STATUS: rd_d = {28'h0000000, int_status};
        `RFX_REG_MASK: rd_d = {28'h0000000, int_mask};
        `RFX_REG_CTRL: rd_d = {24'h000000, halted, st_q == rfx_pkg::RFX_ST_RUN,
                              in_exc_q, 4'h0, lmv_q};
        `RFX_REG_PC: rd_d = pc_q;
        `RFX_REG_SR: rd_d = {16'h0000, sr_q};
        `RFX_REG_VBR: rd_d = vbr_q;
        default: rd_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      rd_q <= 32'h00000000;
    else if (ce)
      rd_q <= rd_d;
  end

  assign reg_rdata = rd_q;
endmodule
`default_nettype wire

// ===== core/rfx_defs.svh
`ifndef RFX_DEFS_SVH
`define RFX_DEFS_SVH
// ********************************************************
// status word field positions
// ********************************************************
`define RFX_SR_T_BIT 15
`define RFX_SR_S_BIT 13
`define RFX_SR_M_BIT 12
`define RFX_SR_IPL_LSB 8
`define RFX_SR_IPL_MSB 10
`define RFX_IPL_MAX 3'h7
`define RFX_SR_RESET 16'h2700
// ********************************************************
// vectors and addresses
// ********************************************************
`define RFX_VBR_RESET 32'h00000000
`define RFX_RESET_PC_ADDR 32'h00000000
`define RFX_RESET_SP_ADDR 32'h00000004
`define RFX_VEC_UNSUPP 8'h61
// ********************************************************
// register bus offsets
// ********************************************************
`define RFX_REG_STATUS 4'h0
`define RFX_REG_MASK 4'h1
`define RFX_REG_CTRL 4'h2
`define RFX_REG_PC 4'h3
`define RFX_REG_SR 4'h4
`define RFX_REG_VBR 4'h5
`define RFX_INT_W 4
`endif

// ===== core/rfx_irq.sv
`timescale 1ns/1ns
`default_nettype none
// ********************************************************
// sticky event status with mask, write one to clear
// ********************************************************
module rfx_irq
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [3:0] evt,
  input wire logic clr_we,
  input wire logic [3:0] clr_bits,
  input wire logic mask_we,
  input wire logic [3:0] mask_wdata,
  output logic [3:0] status,
  output logic [3:0] mask,
  output logic irq
);
  logic [3:0] st_q;
  logic [3:0] st_d;
  logic [3:0] mk_q;
  logic [3:0] mk_d;

  // a new event beats a clear landing in the same cycle
  always_comb
  begin
    st_d = st_q;
    if (clr_we)
      st_d = st_d & ~clr_bits;
    st_d = st_d | evt;
    mk_d = mask_we ? mask_wdata : mk_q;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      st_q <= 4'h0;
      mk_q <= 4'h0;
    end
    else if (ce)
    begin
      st_q <= st_d;
      mk_q <= mk_d;
    end
  end

  assign status = st_q;
  assign mask = mk_q;
  assign irq = |(st_q & mk_q);
endmodule
`default_nettype wire

// ===== core/rfx_pkg.sv
package rfx_pkg;
  typedef enum logic [5:0] {
    RFX_ST_RESET = 6'h01,
    RFX_ST_RD0 = 6'h02,
    RFX_ST_RD1 = 6'h04,
    RFX_ST_FETCH = 6'h08,
    RFX_ST_RUN = 6'h10,
    RFX_ST_HALT = 6'h20
  } rfx_state_t;

  typedef struct packed {
    logic req;
    logic [31:0] addr;
  } rfx_bus_req_t;

  typedef struct packed {
    logic ack;
    logic access_err;
    logic addr_err;
    logic [31:0] data;
  } rfx_bus_rsp_t;
endpackage

// ===== core/rfx_sync.sv
`timescale 1ns/1ns
`default_nettype none
// ********************************************************
// three-stage pin synchroniser with agreement filter
// ********************************************************
module rfx_sync
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic din,
  output logic dout
);
  logic [2:0] sh_q;
  logic [2:0] sh_d;
  logic out_q;
  logic out_d;

  // stage one feeds only stage two; output moves once 2 and 3 agree
  always_comb
  begin
    sh_d = {sh_q[1:0], din};
    out_d = (sh_q[2] == sh_q[1]) ? sh_q[2] : out_q;
  end

  // reset value models an asserted request so the core starts aborted
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      sh_q <= 3'h0;
      out_q <= 1'b0;
    end
    else if (ce)
    begin
      sh_q <= sh_d;
      out_q <= out_d;
    end
  end

  assign dout = out_q;
endmodule
`default_nettype wire

// ===== tb/reset_and_fault_exception_ctl_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module reset_and_fault_exception_ctl_tb_top;
  logic clk = 1'b0, nrst = 1'b0, ce = 1'b1, reset_request_in_n = 1'b0;
  logic hold_halt = 1'b0, fetch_done = 1'b0, opcode_valid = 1'b0;
  logic unit_absent = 1'b0, fault = 1'b0, exc_done = 1'b0;
  logic reg_we = 1'b0, reg_re = 1'b0;
  logic [3:0] reg_addr = 4'h0, wait_n = 4'h0;
  logic [31:0] reg_wdata = 32'h0, pc_val = 32'h00001234;
  logic [1:0] err_sel = 2'h0;
  logic exc_take, core_run, halted, local_mem_valid, irq;
  logic [7:0] exc_vector;
  logic [15:0] processor_status_word;
  logic [31:0] vector_base_pointer, program_counter, stack_pointer, reg_rdata;
  rfx_pkg::rfx_bus_req_t bus_req;
  rfx_pkg::rfx_bus_rsp_t bus_rsp;
  int n_errors = 0, n_compared = 0;
  always #2 clk = ~clk;
  rfx_ctl i_dut (.clk, .nrst, .ce, .reset_request_in_n, .hold_halt,
    .bus_req, .bus_rsp, .fetch_done, .opcode_valid, .unit_absent, .fault,
    .exc_done, .exc_take, .exc_vector, .core_run, .halted,
    .processor_status_word, .vector_base_pointer, .program_counter,
    .stack_pointer, .local_mem_valid, .reg_addr, .reg_wdata, .reg_we,
    .reg_re, .reg_rdata, .irq);
  rfx_mem_model i_mem (.clk, .bus_req, .bus_rsp, .wait_n, .err_sel, .pc_val);
  // ********************************************************
  // shared tasks
  // ********************************************************
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge clk);
    reg_we <= 1'b0;
    #1;
  endtask
  task rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge clk);
    reg_re <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task pulse_fault;
    @(posedge clk);
    fault <= 1'b1;
    @(posedge clk);
    fault <= 1'b0;
    #1;
  endtask
  // pin reset, optional hold, then the two vector reads; a slow answer
  // and a start held for 20 cycles after pin release are both covered by the arguments
  // lmv is set first so the reset must clear it
  task boot(input logic [1:0] e, input logic h, input logic [3:0] w);
    wr(4'h2, 32'h1);
    err_sel = e;
    wait_n = w;
    @(posedge clk);
    hold_halt <= h;
    reset_request_in_n <= 1'b0;
    repeat (8) @(posedge clk);
    #1 chk("halt exit", halted, 1'b0);
    @(posedge clk);
    reset_request_in_n <= 1'b1;
    if (h)
    begin
      repeat (20) @(posedge clk);
      #1 chk("held", bus_req.req, 1'b0);
      @(posedge clk);
      hold_halt <= 1'b0;
    end
    repeat (200)
    begin
      @(posedge clk);
      #1;
      if (halted === 1'b1 || (bus_rsp.ack === 1'b1 && bus_req.addr[2]))
        break;
    end
    if (e != 2'h0)
      chk("fetch error", halted, 1'b1);
    else
    begin
      @(posedge clk);
      fetch_done <= 1'b1;
      @(posedge clk);
      fetch_done <= 1'b0;
      #1 chk("run", core_run, 1'b1);
      chk("pc", program_counter, pc_val);
      chk("sp", stack_pointer, ~pc_val);
      chk("sr", processor_status_word, 16'h2700);
      chk("vbr", vector_base_pointer, 32'h00000000);
      chk("lmv", local_mem_valid, 1'b0);
    end
  endtask
  // ********************************************************
  // scenarios
  // ********************************************************
  task t_unsupp_irq;
    logic [31:0] d;
    @(posedge clk);
    opcode_valid <= 1'b1;
    unit_absent <= 1'b1;
    @(posedge clk);
    opcode_valid <= 1'b0;
    unit_absent <= 1'b0;
    #1 chk("take", exc_take, 1'b1);
    chk("vector", exc_vector, 8'h61);
    chk("irq masked", irq, 1'b0);
    wr(4'h1, 32'h2);
    chk("irq on", irq, 1'b1);
    wr(4'h0, 32'h2);
    chk("irq clear", irq, 1'b0);
    rd(4'hf, d);
    chk("unmapped", d, 32'h0);
    wr(4'h2, 32'h1);
    chk("lmv set", local_mem_valid, 1'b1);
    rd(4'h2, d);
    chk("ctrl run", d, 32'h41);
    rd(4'h3, d);
    chk("pc reg", d, pc_val);
    rd(4'h4, d);
    chk("sr reg", d, 32'h2700);
    rd(4'h5, d);
    chk("vbr reg", d, 32'h0);
  endtask
  // a fault closed by exc_done is harmless; two open faults halt
  task t_faults;
    logic [31:0] d;
    // two faults while frozen must leave no trace
    @(posedge clk);
    ce <= 1'b0;
    pulse_fault();
    pulse_fault();
    chk("frozen", halted, 1'b0);
    @(posedge clk);
    ce <= 1'b1;
    pulse_fault();
    @(posedge clk);
    exc_done <= 1'b1;
    @(posedge clk);
    exc_done <= 1'b0;
    pulse_fault();
    chk("one fault", halted, 1'b0);
    pulse_fault();
    chk("double fault", halted, 1'b1);
    repeat (12) @(posedge clk);
    #1 chk("stay halted", halted, 1'b1);
    chk("no run", core_run, 1'b0);
    rd(4'h2, d);
    chk("ctrl halt", d, 32'h81);
    rd(4'h0, d);
    chk("status", d, 32'hc);
  endtask
  task conclude;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // main sequence
  initial
  begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    boot(2'h0, 1'b1, 4'h0);
    t_unsupp_irq();
    t_faults();
    boot(2'h2, 1'b0, 4'h3);
    boot(2'h1, 1'b0, 4'h1);
    boot(2'h0, 1'b0, 4'h5);
    conclude();
  end
  // the run needs some 200 cycles; a hang is cut at thirty times that
  initial
  begin
    #24000;
    n_errors++;
    conclude();
  end
endmodule
bind rfx_ctl rfx_properties i_chk (.clk(clk), .nrst(nrst),
  .reset_request_in_n(reset_request_in_n), .bus_req(bus_req),
  .bus_rsp(bus_rsp), .fetch_done(fetch_done), .opcode_valid(opcode_valid),
  .unit_absent(unit_absent), .exc_take(exc_take), .exc_vector(exc_vector),
  .core_run(core_run), .halted(halted),
  .processor_status_word(processor_status_word),
  .vector_base_pointer(vector_base_pointer),
  .program_counter(program_counter), .local_mem_valid(local_mem_valid));
`default_nettype wire

// ===== tb/rfx_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
// ********************************************************
// memory answering the reset vector reads
// ********************************************************
module rfx_mem_model
(
  input wire logic clk,
  input wire rfx_pkg::rfx_bus_req_t bus_req,
  output rfx_pkg::rfx_bus_rsp_t bus_rsp,
  input wire logic [3:0] wait_n,
  input wire logic [1:0] err_sel,
  input wire logic [31:0] pc_val
);
  logic [3:0] cnt_q = 4'h0;
  rfx_pkg::rfx_bus_rsp_t rsp_q = '0;
  // data is inverted outside the ack so stale words never look valid
  always @(posedge clk)
  begin
    if (bus_req.req && !rsp_q.ack && cnt_q == wait_n)
    begin
      rsp_q <= '{ack: 1'b1, access_err: err_sel[0], addr_err: err_sel[1],
        data: bus_req.addr[2] ? ~pc_val : pc_val};
      cnt_q <= 4'h0;
    end
    else
    begin
      rsp_q <= '{ack: 1'b0, access_err: 1'b0, addr_err: 1'b0,
        data: ~rsp_q.data};
      cnt_q <= (bus_req.req && !rsp_q.ack) ? cnt_q + 4'h1 : 4'h0;
    end
  end
  // one driver for the response, the register above
  assign bus_rsp = rsp_q;
endmodule
`default_nettype wire

// ===== tb/rfx_properties.sv
`timescale 1ns/1ns
`default_nettype none
// ********************************************************
// reset fetch and fault checks
// ********************************************************
module rfx_properties
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic reset_request_in_n,
  input wire rfx_pkg::rfx_bus_req_t bus_req,
  input wire rfx_pkg::rfx_bus_rsp_t bus_rsp,
  input wire logic fetch_done,
  input wire logic opcode_valid,
  input wire logic unit_absent,
  input wire logic exc_take,
  input wire logic [7:0] exc_vector,
  input wire logic core_run,
  input wire logic halted,
  input wire logic [15:0] processor_status_word,
  input wire logic [31:0] vector_base_pointer,
  input wire logic [31:0] program_counter,
  input wire logic local_mem_valid
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!nrst);
  logic ok_ack;
  logic sr_ok;
  // only an answer without error moves the fetch on
  assign ok_ack = bus_req.req && bus_rsp.ack && !bus_rsp.access_err
    && !bus_rsp.addr_err;
  // bit 14 is unused, so only s, t, m and the mask are compared
  assign sr_ok = {processor_status_word[15], processor_status_word[13:12],
    processor_status_word[10:8]} == 6'h17;
  // machine state while the two vectors are read
  a_sr_in_fetch: assert property (
    bus_req.req |-> sr_ok && vector_base_pointer == 32'h00000000
    && !local_mem_valid)
    else $error("state not in reset form during vector fetch");
  a_first_addr: assert property (
    $rose(bus_req.req) |-> bus_req.addr == 32'h00000000)
    else $error("first read not at address zero");
  a_req_held: assert property (
    bus_req.req && !bus_rsp.ack |=> bus_req.req && $stable(bus_req.addr))
    else $error("read request dropped before answer");
  a_second_read: assert property (
    ok_ack && bus_req.addr == 32'h00000000 |=> bus_req.req
    && bus_req.addr == 32'h00000004)
    else $error("second longword read missing");
  a_pc_load: assert property (
    ok_ack && bus_req.addr == 32'h00000000
    |=> program_counter == $past(bus_rsp.data))
    else $error("counter not loaded from first longword");
  a_err_halt: assert property (
    bus_req.req && bus_rsp.ack && (bus_rsp.access_err || bus_rsp.addr_err)
    |=> halted)
    else $error("fetch error did not halt");
  a_run_fetch: assert property (
    $rose(core_run) |-> $past(fetch_done))
    else $error("run began without a fetched instruction");
  // vector goes with the take pulse and its cause
  a_vec_unsupp: assert property (
    exc_take |-> exc_vector == 8'h61
    && $past(core_run && opcode_valid && unit_absent))
    else $error("unsupported exception wrong");
  // six high samples flush the pin synchroniser first
  a_halt_hold: assert property (
    reset_request_in_n [*6] ##0 halted |=> halted)
    else $error("halt left without reset");
endmodule
`default_nettype wire
